// ### error_flags_regs.svh
// Register offsets, bit positions and reset values of the error-flag bank
`ifndef ERROR_FLAGS_REGS_SVH
`define ERROR_FLAGS_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ERR_FLAG_OFFSET       12'h060
`define ERR_ACK_OFFSET        12'h064
`define ERR_CTRL_OFFSET       12'h050
`define ERR_IRQ_ADDR_LO       12'h068
`define ERR_IRQ_ADDR_HI       12'h06C
`define ERR_SYNDROME_OFFSET   12'h078
`define ERR_CONS_OFFSET       12'h07C

// ----------------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------------
`define BIT_CMD_ERR           0
`define BIT_EVQ_ABT           2
`define BIT_PRQ_ABT           3
`define BIT_SYNC_MSG          4
`define BIT_EVT_MSG           5
`define BIT_PRQ_MSG           6
`define BIT_GLB_MSG           7
`define BIT_SFM               8
`define BIT_CMDP              9
`define BIT_TLF               10
`define NUM_SRC               11
`define CTRL_IRQEN_BIT        0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FLAGS_RESET           11'h000
`define CTRL_RESET            1'h0
`define WORD_ZERO             32'h0000_0000
`define ADDR_LO_MASK          32'hFFFF_FFFC
`define ADDR_HI_MASK          32'h00FF_FFFF

`endif

// ### error_flags_pkg.sv
// Types shared by the error-flag bank
`default_nettype none
package error_flags_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef enum logic [1:0] {
    CMD_RUN  = 2'b00,
    CMD_HALT = 2'b01
  } cmd_state_t;
endpackage
`default_nettype wire

// ### global_error_flags.sv
// Global error flag and acknowledge register bank with APB access
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "error_flags_regs.svh"

module global_error_flags #(
  parameter bit          HAS_TABLE_LOOKUP = 1'b1,
  parameter bit          HAS_EXT_CMDQ     = 1'b1,
  parameter bit          HAS_MSG_IRQ      = 1'b1,
  parameter bit          HAS_PAGE_REQ     = 1'b1,
  parameter int unsigned SYNDROME_W       = 32,
  parameter int unsigned REASON_W         = 7
) (
  // Clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    rst_b_in,
  // APB slave
  input  wire error_flags_pkg::apb_req_t apb_req_in,
  output var  error_flags_pkg::apb_rsp_t apb_rsp_out,
  // Error events, one-cycle pulses from the rest of the unit
  input  wire logic                    table_fault_in,
  input  wire logic [SYNDROME_W-1:0]   table_syndrome_in,
  input  wire logic                    cmd_page_err_in,
  input  wire logic                    service_fail_in,
  input  wire logic                    service_exit_in,
  input  wire logic                    glb_msg_abort_in,
  input  wire logic                    pagereq_msg_abort_in,
  input  wire logic                    event_msg_abort_in,
  input  wire logic                    sync_msg_abort_in,
  input  wire logic                    pagereq_queue_abort_in,
  input  wire logic                    event_queue_abort_in,
  input  wire logic                    cmd_error_in,
  input  wire logic [REASON_W-1:0]     cmd_reason_in,
  // Status and control outputs
  output logic [`NUM_SRC-1:0]          error_active_out,
  output logic                         cmd_halt_out,
  output logic                         traffic_stop_out,
  output logic                         global_irq_out
);

  // --------------------------------------------------------------------
  // Feature mask: absent sources are reserved in both registers
  // --------------------------------------------------------------------
  logic [`NUM_SRC-1:0] impl_mask;
  assign impl_mask = {HAS_TABLE_LOOKUP, HAS_EXT_CMDQ, 1'b1,
                      HAS_MSG_IRQ, HAS_MSG_IRQ & HAS_PAGE_REQ,
                      HAS_MSG_IRQ, HAS_MSG_IRQ, HAS_PAGE_REQ,
                      1'b1, 1'b0, 1'b1};

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  logic [`NUM_SRC-1:0]   error_flag_reg;
  logic [`NUM_SRC-1:0]   error_ack_reg;
  logic [`NUM_SRC-1:0]   ack_prev;
  logic                  global_irq_enable;
  logic [31:0]           irq_addr_lo;
  logic [31:0]           irq_addr_hi;
  logic [SYNDROME_W-1:0] table_fault_syndrome_reg;
  logic [REASON_W-1:0]   consumer_error_field;
  logic                  service_fail_mode;
  logic [`NUM_SRC-1:0]   raw_event;
  logic [`NUM_SRC-1:0]   source_active;
  logic [`NUM_SRC-1:0]   next_error_flag;
  logic [`NUM_SRC-1:0]   new_activation;
  logic [31:0]           rdata_q;

  assign raw_event = {table_fault_in, cmd_page_err_in, service_fail_in,
                      glb_msg_abort_in, pagereq_msg_abort_in,
                      event_msg_abort_in, sync_msg_abort_in,
                      pagereq_queue_abort_in, event_queue_abort_in,
                      1'b0, cmd_error_in};

  // --------------------------------------------------------------------
  // Toggle logic per source
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g++) begin : g_src
      assign source_active[g] = impl_mask[g] &
                                (error_flag_reg[g] ^ error_ack_reg[g]);
      assign next_error_flag[g] = impl_mask[g] &
                                  (error_flag_reg[g] ^
                                   (raw_event[g] & ~source_active[g]));
      assign new_activation[g] = (next_error_flag[g] ^ error_flag_reg[g]) &
                                 ~(error_ack_reg[g] ^ ack_prev[g]);
    end
  endgenerate

  assign error_active_out = source_active;

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  wire logic apb_access = apb_req_in.psel & apb_req_in.penable;
  wire logic apb_wr     = apb_access & apb_req_in.pwrite;
  wire logic hit_flag   = apb_req_in.paddr == `ERR_FLAG_OFFSET;
  wire logic hit_ack    = apb_req_in.paddr == `ERR_ACK_OFFSET;
  wire logic hit_ctrl   = apb_req_in.paddr == `ERR_CTRL_OFFSET;
  wire logic hit_alo    = apb_req_in.paddr == `ERR_IRQ_ADDR_LO;
  wire logic hit_ahi    = apb_req_in.paddr == `ERR_IRQ_ADDR_HI;
  wire logic hit_syn    = apb_req_in.paddr == `ERR_SYNDROME_OFFSET;
  wire logic hit_cons   = apb_req_in.paddr == `ERR_CONS_OFFSET;
  wire logic hit_any    = hit_flag | hit_ack | hit_ctrl | hit_alo |
                          hit_ahi | hit_syn | hit_cons;
  // Address register is guarded: writable only with the enable clear
  // present only with messages
  wire logic addr_wr_ok = HAS_MSG_IRQ & ~global_irq_enable;

  logic [31:0] read_mux;
  always_comb begin
    read_mux = `WORD_ZERO;
    if (hit_flag) begin
      read_mux[`NUM_SRC-1:0] = error_flag_reg;
    end else if (hit_ack) begin
      read_mux[`NUM_SRC-1:0] = error_ack_reg;
    end else if (hit_ctrl) begin
      read_mux[`CTRL_IRQEN_BIT] = global_irq_enable;
    end else if (hit_alo) begin
      read_mux = HAS_MSG_IRQ ? irq_addr_lo : `WORD_ZERO;
    end else if (hit_ahi) begin
      read_mux = HAS_MSG_IRQ ? irq_addr_hi : `WORD_ZERO;
    end else if (hit_syn) begin
      read_mux[SYNDROME_W-1:0] = HAS_TABLE_LOOKUP ?
                                 table_fault_syndrome_reg : '0;
    end else if (hit_cons) begin
      read_mux[REASON_W-1:0] = consumer_error_field;
    end
  end

  // --------------------------------------------------------------------
  // Register updates
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      error_flag_reg    <= `FLAGS_RESET;
      error_ack_reg     <= `FLAGS_RESET;
      ack_prev          <= `FLAGS_RESET;
      global_irq_enable <= `CTRL_RESET;
      irq_addr_lo       <= `WORD_ZERO;
      irq_addr_hi       <= `WORD_ZERO;
    end else begin
      error_flag_reg <= next_error_flag;
      ack_prev       <= error_ack_reg;
      if (apb_wr && hit_ack) begin
        error_ack_reg <= apb_req_in.pwdata[`NUM_SRC-1:0] & impl_mask;
      end
      if (apb_wr && hit_ctrl) begin
        global_irq_enable <= apb_req_in.pwdata[`CTRL_IRQEN_BIT];
      end
      if (apb_wr && hit_alo && addr_wr_ok) begin
        irq_addr_lo <= apb_req_in.pwdata & `ADDR_LO_MASK;
      end
      if (apb_wr && hit_ahi && addr_wr_ok) begin
        irq_addr_hi <= apb_req_in.pwdata & `ADDR_HI_MASK;
      end
    end
  end

  // --------------------------------------------------------------------
  // Syndrome capture and command reason
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      table_fault_syndrome_reg <= '0;
      consumer_error_field     <= '0;
    end else begin
      if (table_fault_in && HAS_TABLE_LOOKUP &&
          !source_active[`BIT_TLF]) begin
        table_fault_syndrome_reg <= table_syndrome_in;
      end
      if (cmd_error_in && !source_active[`BIT_CMD_ERR]) begin
        consumer_error_field <= cmd_reason_in;
      end
    end
  end

  // --------------------------------------------------------------------
  // Service failure mode and command halt
  // --------------------------------------------------------------------
  // Mode is left only by the dedicated exit strobe, never by acknowledge
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      service_fail_mode <= 1'b0;
    end else begin
      if (service_fail_in) begin
        service_fail_mode <= 1'b1;
      end else if (service_exit_in) begin
        service_fail_mode <= 1'b0;
      end
    end
  end

  assign traffic_stop_out = service_fail_mode;
  assign cmd_halt_out = source_active[`BIT_CMD_ERR] |
                        next_error_flag[`BIT_CMD_ERR] ^
                        error_flag_reg[`BIT_CMD_ERR] |
                        service_fail_mode;

  // --------------------------------------------------------------------
  // Interrupt pulse, one per cycle with any new activation, except on a source whose acknowledge bit changed the cycle before
  // --------------------------------------------------------------------
  // message abort flags only record; message writes are elsewhere
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      global_irq_out <= 1'b0;
    end else begin
      global_irq_out <= global_irq_enable & (|new_activation);
    end
  end

  // --------------------------------------------------------------------
  // APB response
  // --------------------------------------------------------------------
  // Read data is held in its own flop so the response struct has one driver
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= `WORD_ZERO;
    end else if (apb_req_in.psel && !apb_req_in.penable) begin
      rdata_q <= read_mux;
    end
  end

  assign apb_rsp_out = '{prdata:  rdata_q,
                         pready:  1'b1,
                         pslverr: apb_access & ~hit_any};

endmodule
`default_nettype wire

// ### global_error_flags_assertions.sv
// Port-level checks for the global error flag bank
`timescale 1ns/1ps
`default_nettype none
module global_error_flags_checker (
  // Clock, reset and register bus
  input wire logic                      mclk_in,
  input wire logic                      rst_b_in,
  input wire error_flags_pkg::apb_req_t apb_req_in,
  input wire error_flags_pkg::apb_rsp_t apb_rsp_out,
  // Error events and status
  input wire logic                      table_fault_in,
  input wire logic                      cmd_page_err_in,
  input wire logic                      service_fail_in,
  input wire logic                      service_exit_in,
  input wire logic                      glb_msg_abort_in,
  input wire logic                      pagereq_msg_abort_in,
  input wire logic                      event_msg_abort_in,
  input wire logic                      sync_msg_abort_in,
  input wire logic                      pagereq_queue_abort_in,
  input wire logic                      event_queue_abort_in,
  input wire logic                      cmd_error_in,
  input wire logic [10:0]               error_active_out,
  input wire logic                      cmd_halt_out,
  input wire logic                      traffic_stop_out
);
  wire logic [10:0] ev = {table_fault_in, cmd_page_err_in, service_fail_in,
    glb_msg_abort_in, pagereq_msg_abort_in, event_msg_abort_in,
    sync_msg_abort_in, pagereq_queue_abort_in, event_queue_abort_in,
    1'b0, cmd_error_in};
  wire logic wr_acc = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite;
  wire logic [11:0] a = apb_req_in.paddr;
  wire logic mapped = a == 12'h050 || a == 12'h060 || a == 12'h064 ||
    a == 12'h068 || a == 12'h06C || a == 12'h078 || a == 12'h07C;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  sequence access_s; apb_req_in.psel && apb_req_in.penable; endsequence
  sequence flag_rd_s; !apb_req_in.pwrite && (a == 12'h060 || a == 12'h064);
  endsequence
  ready_const_a: assert property (apb_rsp_out.pready)
    else $error("pready low");
  slverr_map_a: assert property (access_s |->
    apb_rsp_out.pslverr == !mapped)
    else $error("slave error does not match address map");
  resv_zero_a: assert property (access_s ##0 flag_rd_s |->
    apb_rsp_out.prdata[31:11] == 21'h0 && !apb_rsp_out.prdata[1])
    else $error("reserved flag bits read nonzero");
  event_taken_a: assert property (!wr_acc |=>
    ($past(ev & ~error_active_out) & ~error_active_out) == 11'h000)
    else $error("event on idle source not activated");
  active_hold_a: assert property (!wr_acc |=>
    ($past(error_active_out) & ~error_active_out) == 11'h000)
    else $error("active error cleared without acknowledge");
  no_spurious_a: assert property (!wr_acc |=>
    (error_active_out & ~$past(error_active_out) & ~$past(ev)) == 11'h000)
    else $error("error became active without cause");
  bit1_idle_a: assert property (error_active_out[1] == 1'b0)
    else $error("reserved source active");
  halt_cmd_a: assert property (
    error_active_out[0] || traffic_stop_out |-> cmd_halt_out)
    else $error("commands not halted");
  sfm_enter_a: assert property (
    service_fail_in && !service_exit_in |=> traffic_stop_out)
    else $error("service failure not entered");
  sfm_hold_a: assert property (
    traffic_stop_out && !service_exit_in |=> traffic_stop_out)
    else $error("service failure left without exit");
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the global error flag bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  localparam logic [6:0]  REASON = 7'h5A;
  localparam logic [31:0] SYN    = 32'hC0DE_1234;
  logic                      mclk_in  = 1'b0;
  logic                      rst_b_in = 1'b0;
  error_flags_pkg::apb_req_t req      = '0;
  error_flags_pkg::apb_rsp_t rsp;
  logic [10:0]               ev       = 11'h000;
  logic                      sexit    = 1'b0;
  logic [10:0]               active;
  logic                      halt, stop, irq, err;
  logic [31:0]               rd, xf = 32'h0, xa = 32'h0;
  int                        fail_count = 0, checks = 0, cycles = 0, n;
  always #12.5 mclk_in = ~mclk_in;
  global_error_flags i_global_error_flags (.mclk_in(mclk_in),
    .rst_b_in(rst_b_in), .apb_req_in(req), .apb_rsp_out(rsp),
    .table_fault_in(ev[10]), .table_syndrome_in(SYN),
    .cmd_page_err_in(ev[9]), .service_fail_in(ev[8]),
    .service_exit_in(sexit), .glb_msg_abort_in(ev[7]),
    .pagereq_msg_abort_in(ev[6]), .event_msg_abort_in(ev[5]),
    .sync_msg_abort_in(ev[4]), .pagereq_queue_abort_in(ev[3]),
    .event_queue_abort_in(ev[2]), .cmd_error_in(ev[0]),
    .cmd_reason_in(REASON), .error_active_out(active),
    .cmd_halt_out(halt), .traffic_stop_out(stop), .global_irq_out(irq));
  // ----
  // Bus and event drivers
  // ----
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge mclk_in);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge mclk_in);
    req.penable <= 1'b1;
    @(posedge mclk_in);
    while (rsp.pready !== 1'b1) @(posedge mclk_in);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic pulse(input int b);
    @(posedge mclk_in);
    ev <= 11'h001 << b;
    @(posedge mclk_in);
    ev <= 11'h000;
    @(negedge mclk_in);
  endtask
  // Irq is a one-cycle pulse, so every cycle is looked at
  task automatic count_irq();
    n = 0;
    repeat (4) begin
      if (irq === 1'b1) n++;
      @(negedge mclk_in);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    xfer(12'h060, 1'b0, 32'h0); `CHK(rd, 32'h0)
    xfer(12'h064, 1'b0, 32'h0); `CHK(rd, 32'h0)
    for (int b = 0; b < 11; b++) begin
      if (b == 1) continue;
      pulse(b); `CHK(active[b], 1'b1)
      xf[b] = ~xf[b];
      pulse(b);
      xfer(12'h060, 1'b0, 32'h0); `CHK(rd, xf)
      if (b == 0) begin
        `CHK(halt, 1'b1)
        xfer(12'h07C, 1'b0, 32'h0); `CHK(rd, {25'h0, REASON})
      end
      if (b == 10) begin
        xfer(12'h078, 1'b0, 32'h0); `CHK(rd, SYN)
      end
      if (b == 8) begin
        `CHK(stop, 1'b1)
      end
      xa[b] = ~xa[b];
      xfer(12'h064, 1'b1, xa | 32'hFFFF_F802);
      xfer(12'h064, 1'b0, 32'h0); `CHK(rd, xa)
      @(negedge mclk_in); `CHK(active[b], 1'b0)
      if (b == 0) begin
        `CHK(halt, 1'b0)
      end
      if (b == 8) begin
        `CHK(stop, 1'b1)
        @(posedge mclk_in);
        sexit <= 1'b1;
        @(posedge mclk_in);
        sexit <= 1'b0;
        @(negedge mclk_in); `CHK(stop, 1'b0)
      end
    end
    // Flag register is read-only; writes leave it untouched
    xfer(12'h060, 1'b1, 32'hFFFF_FFFF);
    xfer(12'h060, 1'b0, 32'h0); `CHK(rd, xf)
    xfer(12'h100, 1'b0, 32'h0); `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    xfer(12'h050, 1'b1, 32'h1);
    xfer(12'h068, 1'b1, 32'hFFFF_FFFF);
    xfer(12'h068, 1'b0, 32'h0); `CHK(rd, 32'h0)
    pulse(5); count_irq(); `CHK(n, 1)
    xf[5] = ~xf[5];
    xa[5] = ~xa[5];
    xfer(12'h064, 1'b1, xa); count_irq(); `CHK(n, 0)
    xfer(12'h050, 1'b1, 32'h0);
    xfer(12'h068, 1'b1, 32'hFFFF_FFFF);
    xfer(12'h068, 1'b0, 32'h0); `CHK(rd, 32'hFFFF_FFFC)
    pulse(4); count_irq(); `CHK(n, 0)
    finish_test();
  end
endmodule
bind global_error_flags global_error_flags_checker i_chk (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .apb_req_in(apb_req_in),
  .apb_rsp_out(apb_rsp_out), .table_fault_in(table_fault_in),
  .cmd_page_err_in(cmd_page_err_in), .service_fail_in(service_fail_in),
  .service_exit_in(service_exit_in), .glb_msg_abort_in(glb_msg_abort_in),
  .pagereq_msg_abort_in(pagereq_msg_abort_in),
  .event_msg_abort_in(event_msg_abort_in),
  .sync_msg_abort_in(sync_msg_abort_in),
  .pagereq_queue_abort_in(pagereq_queue_abort_in),
  .event_queue_abort_in(event_queue_abort_in), .cmd_error_in(cmd_error_in),
  .error_active_out(error_active_out), .cmd_halt_out(cmd_halt_out),
  .traffic_stop_out(traffic_stop_out));
`default_nettype wire
